/* pkg/slp_cfg.svh */
// register indices, field positions and sizes for the sleep-off select bank
`ifndef SLP_CFG_SVH
`define SLP_CFG_SVH

`define SLP_ADDR_W        10
`define SLP_DATA_W        32
`define SLP_REG_W         8
`define SLP_N_RAILS       14
`define SLP_N_LOW         8
`define SLP_N_MISC_RAILS  6
`define SLP_IDX_W         8
`define SLP_IDX_OFF_LOW   8'h29
`define SLP_IDX_OFF_MISC  8'h2a
`define SLP_IDX_STATUS    8'h30
`define SLP_ALIGN_LSB     2
`define SLP_BIT_THERM     7
`define SLP_BIT_SLOWCLK   6
`define SLP_STAT_LOADED   0
`define SLP_STAT_SLEEP    1
`define SLP_REG_RST       8'h00

`endif

/* pkg/slp_pkg.sv */
// types shared by the sleep-off select bank
`include "slp_cfg.svh"

package slp_pkg;

   typedef logic [`SLP_N_RAILS-1:0] slp_rail_t;
   typedef logic [`SLP_REG_W-1:0]   slp_byte_t;
   typedef logic [`SLP_DATA_W-1:0]  slp_word_t;
   typedef logic [`SLP_ADDR_W-1:0]  slp_addr_t;

   typedef enum logic [1:0] {
      ST_LOAD,
      ST_ACTIVE,
      ST_SLEEP
   } slp_mode_e;

   typedef struct packed {
      slp_mode_e mode;
      slp_byte_t off_low;
      slp_byte_t off_misc;
      slp_rail_t rail_off;
      slp_rail_t rail_eco;
      logic      therm_off;
      logic      slow_off;
      logic      in_sleep;
      logic      pready;
      logic      pslverr;
      slp_word_t prdata;
   } slp_state_s;

endpackage : slp_pkg

/* pkg/slp_int_if.sv */
// internal carrier between the bank top, its address decoder and its rail mode decoder
`timescale 1ns/1ps

interface slp_int_if;
   import slp_pkg::*;

   slp_addr_t addr;
   logic      hit_low;
   logic      hit_misc;
   logic      hit_status;
   logic      mapped;
   slp_rail_t off_sel;
   slp_rail_t keep;
   slp_rail_t off;
   slp_rail_t low_quiescent_mode;

   modport top  (output addr, off_sel, keep,
                 input  hit_low, hit_misc, hit_status, mapped, off, low_quiescent_mode);
   modport dec  (input  addr,
                 output hit_low, hit_misc, hit_status, mapped);
   modport mode (input  off_sel, keep,
                 output off, low_quiescent_mode);
endinterface : slp_int_if

/* core/slp_addr_dec.sv */
// word address decoder for the sleep-off select bank
`timescale 1ns/1ps
`include "slp_cfg.svh"

module slp_addr_dec (
   // carrier
   slp_int_if.dec ifc
);
   import slp_pkg::*;

   function automatic logic idx_hit(input slp_addr_t a, input logic [`SLP_IDX_W-1:0] idx);
      idx_hit = (a[`SLP_ALIGN_LSB-1:0] == '0) &&
                (a[`SLP_ADDR_W-1:`SLP_ALIGN_LSB] == idx);
   endfunction : idx_hit

   always_comb begin
      ifc.hit_low    = idx_hit(ifc.addr, `SLP_IDX_OFF_LOW);
      ifc.hit_misc   = idx_hit(ifc.addr, `SLP_IDX_OFF_MISC);
      ifc.hit_status = idx_hit(ifc.addr, `SLP_IDX_STATUS);
      ifc.mapped     = ifc.hit_low | ifc.hit_misc | ifc.hit_status;
   end
endmodule : slp_addr_dec

/* core/slp_rail_mode.sv */
// per-rail sleep mode decode: keep-active wins, else off selector picks off or eco
`timescale 1ns/1ps

module slp_rail_mode (
   // carrier
   slp_int_if.mode ifc
);
   import slp_pkg::*;

   always_comb begin
      ifc.off = ifc.off_sel & ~ifc.keep;
      ifc.low_quiescent_mode = ~ifc.off_sel & ~ifc.keep;
   end
endmodule : slp_rail_mode

/* core/slp_bank_top.sv */
// sleep-off select register bank with apb slave and sleep mode control
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "slp_cfg.svh"

module slp_bank_top (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_resetn,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire slp_pkg::slp_addr_t i_paddr,
   input  wire slp_pkg::slp_word_t i_pwdata,
   output logic                   o_pready,
   output slp_pkg::slp_word_t     o_prdata,
   output logic                   o_pslverr,
   // one-time defaults
   input  wire slp_pkg::slp_byte_t i_otp_off_low,
   input  wire slp_pkg::slp_byte_t i_otp_off_misc,
   // power state
   input  wire logic              i_sleep,
   input  wire slp_pkg::slp_rail_t i_keep_active,
   // rail controls
   output slp_pkg::slp_rail_t     o_rail_off,
   output slp_pkg::slp_rail_t     o_rail_eco,
   output logic                   o_thermal_off,
   output logic                   o_slow_clk_off,
   output logic                   o_in_sleep
);
   import slp_pkg::*;

   slp_state_s s_reg;
   slp_state_s s_next;
   slp_int_if  ifc ();

   logic access_done;
   logic wr_done;

   slp_addr_dec u_dec (
      .ifc (ifc)
   );

   slp_rail_mode u_mode (
      .ifc (ifc)
   );

   // rail order: the eight rails of the low register first, then the six rails of the second register
   function automatic slp_rail_t rail_sel(input slp_state_s s);
      rail_sel = {s.off_misc[`SLP_N_MISC_RAILS-1:0], s.off_low};
   endfunction : rail_sel

   assign ifc.addr    = i_paddr;
   assign ifc.off_sel = rail_sel(s_reg);
   assign ifc.keep    = i_keep_active;

   assign access_done = i_psel & i_penable & s_reg.pready;
   assign wr_done     = access_done & i_pwrite & ifc.mapped;

   function automatic slp_word_t read_mux(input slp_state_s s, input logic lo,
                                          input logic mi, input logic st);
      slp_word_t d;
      d = '0;
      if (lo) begin
         d = slp_word_t'(s.off_low);
      end else if (mi) begin
         d = slp_word_t'(s.off_misc);
      end else if (st) begin
         d[`SLP_STAT_LOADED] = (s.mode != ST_LOAD);
         d[`SLP_STAT_SLEEP]  = s.in_sleep;
      end
      read_mux = d;
   endfunction : read_mux

   always_comb begin
      s_next = s_reg;
      // answer one cycle after setup; held off until the defaults are in so no
      // access can race the one-time load
      s_next.pready  = i_psel & ~s_reg.pready & (s_reg.mode != ST_LOAD);
      // error only ever travels with ready, never on its own during the load
      s_next.pslverr = s_next.pready & ~ifc.mapped;
      if (i_psel & ~s_reg.pready) begin
         s_next.prdata = i_pwrite ? '0 :
                         read_mux(s_reg, ifc.hit_low, ifc.hit_misc, ifc.hit_status);
      end
      if (wr_done & ifc.hit_low) begin
         s_next.off_low = i_pwdata[`SLP_REG_W-1:0];
      end
      if (wr_done & ifc.hit_misc) begin
         s_next.off_misc = i_pwdata[`SLP_REG_W-1:0];
      end
      case (s_reg.mode)
         ST_LOAD: begin
            s_next.off_low  = i_otp_off_low;
            s_next.off_misc = i_otp_off_misc;
            s_next.mode     = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (i_sleep) begin
               // settings frozen here; writes during sleep apply at next entry
               s_next.mode      = ST_SLEEP;
               s_next.in_sleep  = 1'b1;
               s_next.rail_off  = ifc.off;
               s_next.rail_eco  = ifc.low_quiescent_mode;
               s_next.therm_off = s_reg.off_misc[`SLP_BIT_THERM];
               s_next.slow_off  = s_reg.off_misc[`SLP_BIT_SLOWCLK];
            end
         end
         ST_SLEEP: begin
            if (!i_sleep) begin
               s_next.mode      = ST_ACTIVE;
               s_next.in_sleep  = 1'b0;
               s_next.rail_off  = '0;
               s_next.rail_eco  = '0;
               s_next.therm_off = 1'b0;
               s_next.slow_off  = 1'b0;
            end
         end
         default: begin
            s_next.mode = ST_LOAD;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         s_reg           <= '0;
         s_reg.mode      <= ST_LOAD;
         s_reg.off_low   <= `SLP_REG_RST;
         s_reg.off_misc  <= `SLP_REG_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign o_pready       = s_reg.pready;
   assign o_prdata       = s_reg.prdata;
   assign o_pslverr      = s_reg.pslverr;
   assign o_rail_off     = s_reg.rail_off;
   assign o_rail_eco     = s_reg.rail_eco;
   assign o_thermal_off  = s_reg.therm_off;
   assign o_slow_clk_off = s_reg.slow_off;
   assign o_in_sleep     = s_reg.in_sleep;

   // checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   a_write_low_reg: assert property (
      wr_done && ifc.hit_low |=> s_reg.off_low == $past(i_pwdata[`SLP_REG_W-1:0]))
      else $error("low selector register did not take written byte");

   a_write_misc_reg: assert property (
      wr_done && ifc.hit_misc |=> s_reg.off_misc == $past(i_pwdata[`SLP_REG_W-1:0]))
      else $error("second selector register did not take written byte");

   a_sleep_off_rails: assert property (
      $rose(o_in_sleep) |-> o_rail_off ==
         ($past(rail_sel(s_reg)) & ~$past(i_keep_active)))
      else $error("rail off set wrong on sleep entry");

   a_keep_wins: assert property (
      $rose(o_in_sleep) |-> ((o_rail_off | o_rail_eco) & $past(i_keep_active)) == '0)
      else $error("kept-active rail not fully active in sleep");

   a_eco_rails: assert property (
      $rose(o_in_sleep) |-> o_rail_eco ==
         (~$past(rail_sel(s_reg)) & ~$past(i_keep_active)))
      else $error("eco mode set wrong on sleep entry");

   a_misc_funcs: assert property (
      $rose(o_in_sleep) |-> o_thermal_off == $past(s_reg.off_misc[`SLP_BIT_THERM]) &&
                            o_slow_clk_off == $past(s_reg.off_misc[`SLP_BIT_SLOWCLK]))
      else $error("thermal or slow clock sleep control wrong");

   a_otp_load: assert property (
      s_reg.mode == ST_LOAD && i_resetn |=> s_reg.off_low == $past(i_otp_off_low) &&
                                s_reg.off_misc == $past(i_otp_off_misc) &&
                                s_reg.mode == ST_ACTIVE)
      else $error("one-time defaults not loaded");

   a_wake_restore: assert property (
      o_in_sleep && !i_sleep |=> !o_in_sleep && o_rail_off == '0 && o_rail_eco == '0 &&
                                 !o_thermal_off && !o_slow_clk_off)
      else $error("normal operation not restored on wake");

   a_sleep_entry: assert property (
      s_reg.mode == ST_ACTIVE && i_sleep |=> o_in_sleep)
      else $error("sleep not entered");

   a_ready_pulse: assert property (
      o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");

   a_unmapped_err: assert property (
      i_psel && !o_pready && !ifc.mapped && s_reg.mode != ST_LOAD |=> o_pready && o_pslverr)
      else $error("unmapped access not flagged");

   a_err_with_ready: assert property (
      o_pslverr |->
         o_pready)
      else $error("error flag raised without ready");

   a_ready_no_wait: assert property (
      i_psel && !o_pready && s_reg.mode != ST_LOAD |=>
         o_pready)
      else $error("ready not given one cycle after setup");

   a_no_ready_load: assert property (
      s_reg.mode == ST_LOAD |=>
         !o_pready)
      else $error("ready given before the defaults were loaded");

   a_read_low: assert property (
      i_psel && !o_pready && !i_pwrite && ifc.hit_low |=>
         o_prdata == slp_word_t'($past(s_reg.off_low)))
      else $error("low selector register read back wrong");

   a_read_misc: assert property (
      i_psel && !o_pready && !i_pwrite && ifc.hit_misc |=>
         o_prdata == slp_word_t'($past(s_reg.off_misc)))
      else $error("second selector register read back wrong");

   a_read_status: assert property (
      i_psel && !o_pready && !i_pwrite && ifc.hit_status |=>
         o_prdata == slp_word_t'({$past(s_reg.in_sleep), $past(s_reg.mode != ST_LOAD)}))
      else $error("status register read back wrong");

   a_err_data_zero: assert property (
      o_pslverr |->
         o_prdata == '0)
      else $error("refused access returned data");

   a_low_holds: assert property (
      !(wr_done && ifc.hit_low) && s_reg.mode != ST_LOAD |=>
         $stable(s_reg.off_low))
      else $error("low selector register changed without a write");

   a_misc_holds: assert property (
      !(wr_done && ifc.hit_misc) && s_reg.mode != ST_LOAD |=>
         $stable(s_reg.off_misc))
      else $error("second selector register changed without a write");

   a_off_eco_apart: assert property (
      1'b1 |->
         (o_rail_off & o_rail_eco) == '0)
      else $error("rail both off and in eco mode");

   a_awake_idle: assert property (
      !o_in_sleep |->
         o_rail_off == '0 && o_rail_eco == '0 && !o_thermal_off && !o_slow_clk_off)
      else $error("sleep controls active while awake");

   a_sleep_frozen: assert property (
      o_in_sleep && i_sleep |=>
         o_in_sleep && $stable(o_rail_off) && $stable(o_rail_eco) &&
         $stable(o_thermal_off) && $stable(o_slow_clk_off))
      else $error("sleep controls moved during sleep");

   c_write_low:   cover property (wr_done && ifc.hit_low);
   c_eco_entry:   cover property ($rose(o_in_sleep) && o_rail_eco != '0);
   c_sleep_entry: cover property ($rose(o_in_sleep) && o_rail_off != '0);
   c_wake:        cover property ($fell(o_in_sleep));
   c_bad_addr:    cover property (o_pready && o_pslverr);

endmodule : slp_bank_top

/* verification/slp_apb_host.sv */
// apb host model that issues single register transfers to the bank
`timescale 1ns/1ps

module slp_apb_host (
   // clock
   input  wire logic               i_clk,
   // apb master side
   output logic                    o_psel,
   output logic                    o_penable,
   output logic                    o_pwrite,
   output slp_pkg::slp_addr_t      o_paddr,
   output slp_pkg::slp_word_t      o_pwdata,
   input  wire logic               i_pready,
   input  wire slp_pkg::slp_word_t i_prdata,
   input  wire logic               i_pslverr
);
   import slp_pkg::*;

   initial begin
      o_psel    = 1'b0;
      o_penable = 1'b0;
      o_pwrite  = 1'b0;
      o_paddr   = '0;
      o_pwdata  = '0;
   end

   // request held until pready is seen; only the bench watchdog ends a wait on a dead slave
   task automatic xfer(input logic wr, input slp_addr_t a, input slp_word_t d,
                       output slp_word_t rd, output logic err);
      @(posedge i_clk);
      o_psel    <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite  <= wr;
      o_paddr   <= a;
      o_pwdata  <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (i_pready !== 1'b1);
      rd  = i_prdata;
      err = i_pslverr;
      o_psel    <= 1'b0;
      o_penable <= 1'b0;
   endtask : xfer
endmodule : slp_apb_host

/* verification/sleep_off_select_registers_tb.sv */
// self-checking bench for the sleep-off select register bank
`timescale 1ns/1ps

module sleep_off_select_registers_tb;
   import slp_pkg::*;

   logic      clk, resetn, psel, penable, pwrite, pready, pslverr, sleep;
   logic      therm_off, slow_off, in_sleep;
   slp_addr_t paddr;
   slp_word_t pwdata, prdata;
   slp_byte_t otp_low, otp_misc;
   slp_rail_t keep, rail_off, rail_eco;
   int        num_errors, total_checks;
   slp_word_t pat [3] = '{32'h0000_00ff, 32'hffff_ff00, 32'h1234_56a5};

   slp_bank_top slp_bank_top_inst (.i_clk(clk), .i_resetn(resetn), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_otp_off_low(otp_low),
      .i_otp_off_misc(otp_misc), .i_sleep(sleep), .i_keep_active(keep),
      .o_rail_off(rail_off), .o_rail_eco(rail_eco), .o_thermal_off(therm_off),
      .o_slow_clk_off(slow_off), .o_in_sleep(in_sleep));

   slp_apb_host slp_apb_host_inst (.i_clk(clk), .o_psel(psel), .o_penable(penable),
      .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata), .i_pready(pready),
      .i_prdata(prdata), .i_pslverr(pslverr));

   task automatic chk_word(input string nm, input slp_word_t e, input slp_word_t g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_rail(input string nm, input slp_rail_t e, input slp_rail_t g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_rail

   task automatic rd(input slp_addr_t a, input slp_word_t e, input logic ee);
      slp_word_t d;
      logic      er;
      slp_apb_host_inst.xfer(1'b0, a, '0, d, er);
      chk_word("read data", e, d);
      chk_word("read error", {31'h0, ee}, {31'h0, er});
   endtask : rd

   task automatic wr(input slp_addr_t a, input slp_word_t v, input logic ee);
      slp_word_t d;
      logic      er;
      slp_apb_host_inst.xfer(1'b1, a, v, d, er);
      chk_word("write error", {31'h0, ee}, {31'h0, er});
   endtask : wr

   task automatic sleep_case(input slp_byte_t lo, input slp_byte_t mi, input slp_rail_t kp);
      slp_rail_t sel;
      sel = {mi[5:0], lo};
      wr(10'h0a4, {24'h0, lo}, 1'b0);
      wr(10'h0a8, {24'h0, mi}, 1'b0);
      keep  <= kp;
      sleep <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk_rail("rail off", sel & ~kp, rail_off);
      chk_rail("rail eco", ~sel & ~kp, rail_eco);
      chk_word("misc off", {29'h0, mi[7], mi[6], 1'b1}, {29'h0, therm_off, slow_off, in_sleep});
      rd(10'h0c0, 32'h3, 1'b0);
      // changes made while asleep must wait for the next entry
      wr(10'h0a4, {24'h0, ~lo}, 1'b0);
      wr(10'h0a8, {24'h0, ~mi}, 1'b0);
      keep <= ~kp;
      @(posedge clk);
      #1;
      chk_rail("frozen off", sel & ~kp, rail_off);
      @(posedge clk);
      sleep <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk_word("wake", 32'h0, {1'b0, rail_off, rail_eco, therm_off, slow_off, in_sleep});
      $display("sleep case done");
   endtask : sleep_case

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   initial begin
      num_errors   = 0;
      total_checks = 0;
      resetn   = 1'b0;
      otp_low  = 8'h19;
      otp_misc = 8'h04;
      sleep    = 1'b0;
      keep     = '0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(10'h0a4, 32'h19, 1'b0);
      rd(10'h0a8, 32'h04, 1'b0);
      rd(10'h0c0, 32'h1, 1'b0);
      $display("reset defaults done");
      for (int i = 0; i < 3; i++) begin
         wr(10'h0a4, pat[i], 1'b0);
         wr(10'h0a8, ~pat[i], 1'b0);
         rd(10'h0a4, {24'h0, pat[i][7:0]}, 1'b0);
         rd(10'h0a8, {24'h0, ~pat[i][7:0]}, 1'b0);
      end
      wr(10'h0c0, 32'hff, 1'b0);
      rd(10'h0c0, 32'h1, 1'b0);
      rd(10'h0a0, 32'h0, 1'b1);
      wr(10'h0a5, 32'hff, 1'b1);
      rd(10'h0a4, 32'ha5, 1'b0);
      $display("register access done");
      sleep_case(8'hf0, 8'h8a, 14'h0f0f);
      sleep_case(8'h0f, 8'h45, 14'h30f0);
      sleep_case(8'hff, 8'hff, 14'h0000);
      // a second power-on reset must reload the defaults of another variant
      otp_low  <= 8'h1a;
      otp_misc <= 8'h40;
      resetn   <= 1'b0;
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      rd(10'h0a4, 32'h1a, 1'b0);
      rd(10'h0a8, 32'h40, 1'b0);
      rd(10'h0c0, 32'h1, 1'b0);
      $display("second reset done");
      stop_test();
   end
endmodule : sleep_off_select_registers_tb
